// ==== src/otpsc_pkg.sv ====
// constants for the one-time memory and security configuration block
package otpsc_pkg;
    // ----------------------------------------------------------------
    // storage geometry
    // ----------------------------------------------------------------
    localparam int NUM_SECTORS = 4;
    localparam int ROWS_PER_SECTOR = 512;
    localparam int WORD_W = 32;
    localparam int ROW_W = 9;
    localparam int SECT_W = 2;
    localparam int IDX_W = ROW_W + SECT_W;
    localparam int NUM_WORDS = NUM_SECTORS * ROWS_PER_SECTOR;
    localparam logic [IDX_W-1:0] LAST_IDX = 11'h7ff;

    // ----------------------------------------------------------------
    // security word bit positions
    // ----------------------------------------------------------------
    localparam int SEC_JTAG_OFF = 0;
    localparam int SEC_LINK_OFF = 1;
    localparam int SEC_OTP_BOOT = 5;
    localparam int SEC_REDUNDANT = 7;
    localparam int SEC_LOCK0 = 8;
    localparam int SEC_MASTER_LOCK = 12;
    localparam int SEC_JTAG_OTP_OFF = 13;
    localparam int SEC_DEBUG_OFF = 14;
    localparam int SEC_GP_LO = 15;
    localparam int SEC_GP_HI = 21;
    localparam int SEC_UID_LO = 22;
    localparam int SEC_UID_HI = 31;
    localparam logic [WORD_W-1:0] SEC_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // programming port resources and control codes
    // ----------------------------------------------------------------
    localparam int RES_W = 24;
    localparam logic [RES_W-1:0] RES_ADDR = 24'h10_0200;
    localparam logic [RES_W-1:0] RES_DATA = 24'h20_0100;
    localparam logic [RES_W-1:0] RES_CTRL = 24'h10_0300;
    localparam int ADDR_PORT_W = 16;
    localparam int CTRL_PORT_W = 16;
    localparam int CTRL_PROG_ROW = 0;
    localparam int CTRL_PROG_SEC = 1;
    localparam logic [ADDR_PORT_W-1:0] PADDR_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int AXI_AW = 12;
    localparam logic [AXI_AW-1:0] REG_SEC = 12'h000;
    localparam logic [AXI_AW-1:0] REG_CTRL = 12'h004;
    localparam logic [AXI_AW-1:0] REG_STATUS = 12'h008;
    localparam int CTRL_PROG_EN = 0;
    localparam int CTRL_RELOAD = 1;
    localparam int STAT_LOADED = 0;
    localparam int STAT_REFUSED = 1;
    localparam int STAT_JDENIED = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // load sequence states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_LOAD = 4'h1,
        ST_COPY = 4'h2,
        ST_BOOT = 4'h4,
        ST_RUN = 4'h8
    } otpsc_state_t;
endpackage

// ==== src/otpsc_top.sv ====
// one-time memory with power-up security word, programming port and axi
`timescale 1ns/1ns

module otpsc_top (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    // programming port resources from the core
    input wire logic prog_we,
    input wire logic [otpsc_pkg::RES_W-1:0] prog_res_id,
    input wire logic [otpsc_pkg::WORD_W-1:0] prog_wdata,
    // boundary-scan memory access
    input wire logic jtag_req,
    input wire logic jtag_we,
    input wire logic [otpsc_pkg::IDX_W-1:0] jtag_addr,
    input wire logic [otpsc_pkg::WORD_W-1:0] jtag_wdata,
    output logic jtag_rvalid_q,
    output logic jtag_denied_q,
    output logic [otpsc_pkg::WORD_W-1:0] jtag_rdata_q,
    // copy to sram and boot
    output logic copy_valid_q,
    output logic [otpsc_pkg::IDX_W-1:0] copy_addr_q,
    output logic [otpsc_pkg::WORD_W-1:0] copy_data_q,
    output logic boot_valid_q,
    output logic boot_otp_q,
    output logic [otpsc_pkg::IDX_W-1:0] boot_addr_q,
    // protection outputs
    output logic jtag_block_q,
    output logic link_block_q,
    output logic debug_pin_off_q,
    output logic redundant_en_q,
    output logic [9:0] usercode_q,
    // axi4-lite slave
    input wire logic [otpsc_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready_q,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready_q,
    output logic [1:0] s_axi_bresp_q,
    output logic s_axi_bvalid_q,
    input wire logic s_axi_bready,
    input wire logic [otpsc_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready_q,
    output logic [31:0] s_axi_rdata_q,
    output logic [1:0] s_axi_rresp_q,
    output logic s_axi_rvalid_q,
    input wire logic s_axi_rready
);
    // ----------------------------------------------------------------
    // storage and state
    // ----------------------------------------------------------------
    logic [otpsc_pkg::WORD_W-1:0] mem_q [0:otpsc_pkg::NUM_WORDS-1];
    logic [otpsc_pkg::WORD_W-1:0] otp_sec_q;
    logic [otpsc_pkg::WORD_W-1:0] sec_q;
    otpsc_pkg::otpsc_state_t st_q;
    logic [otpsc_pkg::IDX_W-1:0] copy_idx_q;
    logic [otpsc_pkg::ADDR_PORT_W-1:0] paddr_q;
    logic [otpsc_pkg::WORD_W-1:0] pdata_q;
    logic prog_en_q;
    logic reload_q;
    logic refused_q;
    logic jdenied_q;
    logic [otpsc_pkg::AXI_AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // ----------------------------------------------------------------
    // programming decode
    // ----------------------------------------------------------------
    logic ctrl_hit;
    logic [otpsc_pkg::CTRL_PORT_W-1:0] ctrl_val;
    logic [otpsc_pkg::SECT_W-1:0] p_sect;
    logic p_range_ok;
    logic p_row_ok;
    logic p_sec_ok;
    logic j_sect_ok;
    logic j_allowed;
    logic wr_go;
    logic wr_sec_go;
    logic [otpsc_pkg::IDX_W-1:0] wr_idx;
    logic [otpsc_pkg::WORD_W-1:0] wr_data;
    logic j_wr_go;
    logic refuse_evt;
    logic running;

    // command decode; programming waits until the locks are known
    assign running = (st_q == otpsc_pkg::ST_RUN);
    assign ctrl_hit = prog_we
        && (prog_res_id == otpsc_pkg::RES_CTRL);
    assign ctrl_val = prog_wdata[otpsc_pkg::CTRL_PORT_W-1:0];
    assign p_sect = paddr_q[otpsc_pkg::IDX_W-1:otpsc_pkg::ROW_W];
    assign p_range_ok = (paddr_q[otpsc_pkg::ADDR_PORT_W-1:otpsc_pkg::IDX_W]
        == 5'h00);
    assign p_row_ok = ctrl_hit && ctrl_val[otpsc_pkg::CTRL_PROG_ROW]
        && running && prog_en_q && p_range_ok
        && !sec_q[otpsc_pkg::SEC_MASTER_LOCK]
        && !sec_q[otpsc_pkg::SEC_LOCK0 + 32'(p_sect)];
    assign p_sec_ok = ctrl_hit && ctrl_val[otpsc_pkg::CTRL_PROG_SEC]
        && running && prog_en_q
        && !sec_q[otpsc_pkg::SEC_MASTER_LOCK];
    // scan writes obey the same locks and yield to the core port
    assign j_sect_ok = !sec_q[otpsc_pkg::SEC_LOCK0
        + 32'(jtag_addr[otpsc_pkg::IDX_W-1:otpsc_pkg::ROW_W])]
        && !sec_q[otpsc_pkg::SEC_MASTER_LOCK];
    assign j_allowed = running && !sec_q[otpsc_pkg::SEC_JTAG_OFF]
        && !sec_q[otpsc_pkg::SEC_JTAG_OTP_OFF];
    assign j_wr_go = jtag_req && jtag_we && j_allowed && j_sect_ok
        && !p_row_ok;
    assign wr_go = p_row_ok || j_wr_go;
    assign wr_sec_go = p_sec_ok;
    assign wr_idx = p_row_ok ? paddr_q[otpsc_pkg::IDX_W-1:0] : jtag_addr;
    assign wr_data = p_row_ok ? pdata_q : jtag_wdata;
    assign refuse_evt = (ctrl_hit && !p_row_ok && !p_sec_ok)
        || (jtag_req && jtag_we && j_allowed && !j_wr_go);

    // ----------------------------------------------------------------
    // address and data port resources
    // ----------------------------------------------------------------
    // latched values only; nothing is programmed until a command arrives
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            paddr_q <= otpsc_pkg::PADDR_RESET;
            pdata_q <= otpsc_pkg::SEC_RESET;
        end
        else if (ce && prog_we)
        begin
            if (prog_res_id == otpsc_pkg::RES_ADDR)
                paddr_q <= prog_wdata[otpsc_pkg::ADDR_PORT_W-1:0];
            if (prog_res_id == otpsc_pkg::RES_DATA)
                pdata_q <= prog_wdata;
        end
    end

    // ----------------------------------------------------------------
    // fused storage, one word per entry
    // ----------------------------------------------------------------
    // fuses only ever go from 0 to 1; reset stands for a blank part
    for (genvar i = 0; i < otpsc_pkg::NUM_WORDS; i++)
    begin : g_word
        always_ff @(posedge core_clk)
        begin
            if (reset)
                mem_q[i] <= otpsc_pkg::SEC_RESET;
            else if (ce && wr_go && (wr_idx == otpsc_pkg::IDX_W'(i)))
                mem_q[i] <= mem_q[i] | wr_data;
        end
    end

    // fused copy of the security word, not the active one
    always_ff @(posedge core_clk)
    begin
        if (reset)
            otp_sec_q <= otpsc_pkg::SEC_RESET;
        else if (ce && wr_sec_go)
            otp_sec_q <= otp_sec_q | pdata_q;
    end

    // ----------------------------------------------------------------
    // load, copy and boot sequence
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st_q <= otpsc_pkg::ST_LOAD;
            sec_q <= otpsc_pkg::SEC_RESET;
            copy_idx_q <= '0;
            copy_valid_q <= 1'b0;
            copy_addr_q <= '0;
            copy_data_q <= '0;
            boot_valid_q <= 1'b0;
            boot_otp_q <= 1'b0;
            boot_addr_q <= '0;
        end
        else if (ce)
        begin
            boot_valid_q <= 1'b0;
            copy_valid_q <= 1'b0;
            unique case (st_q)
                otpsc_pkg::ST_LOAD:
                begin
                    sec_q <= otp_sec_q;
                    copy_idx_q <= '0;
                    st_q <= otpsc_pkg::ST_COPY;
                end
                otpsc_pkg::ST_COPY:
                begin
                    copy_valid_q <= 1'b1;
                    copy_addr_q <= copy_idx_q;
                    copy_data_q <= mem_q[copy_idx_q];
                    copy_idx_q <= copy_idx_q + 11'h001;
                    if (copy_idx_q == otpsc_pkg::LAST_IDX)
                        st_q <= otpsc_pkg::ST_BOOT;
                end
                otpsc_pkg::ST_BOOT:
                begin
                    boot_valid_q <= 1'b1;
                    boot_otp_q <= sec_q[otpsc_pkg::SEC_OTP_BOOT];
                    boot_addr_q <= '0;
                    st_q <= otpsc_pkg::ST_RUN;
                end
                otpsc_pkg::ST_RUN:
                begin
                    if (reload_q)
                        st_q <= otpsc_pkg::ST_LOAD;
                end
                default:
                    st_q <= otpsc_pkg::ST_LOAD;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // protection outputs
    // ----------------------------------------------------------------
    // held inactive until the load, then follow the active word
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            jtag_block_q <= 1'b0;
            link_block_q <= 1'b0;
            debug_pin_off_q <= 1'b0;
            redundant_en_q <= 1'b0;
            usercode_q <= '0;
        end
        else if (ce && st_q == otpsc_pkg::ST_LOAD)
        begin
            jtag_block_q <= otp_sec_q[otpsc_pkg::SEC_JTAG_OFF];
            link_block_q <= otp_sec_q[otpsc_pkg::SEC_LINK_OFF];
            debug_pin_off_q <= otp_sec_q[otpsc_pkg::SEC_DEBUG_OFF];
            redundant_en_q <= otp_sec_q[otpsc_pkg::SEC_REDUNDANT];
            usercode_q <= otp_sec_q[otpsc_pkg::SEC_UID_HI:
                otpsc_pkg::SEC_UID_LO];
        end
    end

    // ----------------------------------------------------------------
    // boundary-scan read answer
    // ----------------------------------------------------------------
    // a denied access answers zero so no fused data leaks out
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            jtag_rvalid_q <= 1'b0;
            jtag_denied_q <= 1'b0;
            jtag_rdata_q <= '0;
        end
        else if (ce)
        begin
            jtag_rvalid_q <= jtag_req;
            jtag_denied_q <= jtag_req && !j_allowed;
            jtag_rdata_q <= (jtag_req && !jtag_we && j_allowed)
                ? mem_q[jtag_addr] : '0;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    logic wr_fire;
    logic wr_ctrl;
    logic wr_stat;
    assign wr_fire = !s_axi_awready_q && !s_axi_wready_q && !s_axi_bvalid_q;
    assign wr_ctrl = wr_fire && (awaddr_q == otpsc_pkg::REG_CTRL)
        && wstrb_q[0];
    assign wr_stat = wr_fire && (awaddr_q == otpsc_pkg::REG_STATUS)
        && wstrb_q[0];

    // address and data taken in either order, answer after both
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            s_axi_awready_q <= 1'b1;
            s_axi_wready_q <= 1'b1;
            s_axi_bvalid_q <= 1'b0;
            s_axi_bresp_q <= otpsc_pkg::RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready_q)
            begin
                s_axi_awready_q <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready_q)
            begin
                s_axi_wready_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                s_axi_bvalid_q <= 1'b1;
                s_axi_bresp_q <= (awaddr_q == otpsc_pkg::REG_SEC
                    || awaddr_q == otpsc_pkg::REG_CTRL
                    || awaddr_q == otpsc_pkg::REG_STATUS)
                    ? otpsc_pkg::RESP_OKAY : otpsc_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid_q && s_axi_bready)
            begin
                s_axi_bvalid_q <= 1'b0;
                s_axi_awready_q <= 1'b1;
                s_axi_wready_q <= 1'b1;
            end
        end
    end

    // control bits; reload is a one-cycle request
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            prog_en_q <= 1'b0;
            reload_q <= 1'b0;
        end
        else if (ce)
        begin
            reload_q <= wr_ctrl && wdata_q[otpsc_pkg::CTRL_RELOAD];
            if (wr_ctrl)
                prog_en_q <= wdata_q[otpsc_pkg::CTRL_PROG_EN];
        end
    end

    // sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            refused_q <= 1'b0;
            jdenied_q <= 1'b0;
        end
        else if (ce)
        begin
            if (refuse_evt)
                refused_q <= 1'b1;
            else if (wr_stat && wdata_q[otpsc_pkg::STAT_REFUSED])
                refused_q <= 1'b0;
            if (jtag_req && !j_allowed)
                jdenied_q <= 1'b1;
            else if (wr_stat && wdata_q[otpsc_pkg::STAT_JDENIED])
                jdenied_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            s_axi_arready_q <= 1'b1;
            s_axi_rvalid_q <= 1'b0;
            s_axi_rdata_q <= '0;
            s_axi_rresp_q <= otpsc_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready_q)
            begin
                s_axi_arready_q <= 1'b0;
                s_axi_rvalid_q <= 1'b1;
                s_axi_rresp_q <= otpsc_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    otpsc_pkg::REG_SEC:
                        s_axi_rdata_q <= sec_q;
                    otpsc_pkg::REG_CTRL:
                        s_axi_rdata_q <= {31'h0, prog_en_q};
                    otpsc_pkg::REG_STATUS:
                        s_axi_rdata_q <= {24'h0, st_q, 1'b0, jdenied_q,
                            refused_q, running};
                    default:
                    begin
                        s_axi_rdata_q <= '0;
                        s_axi_rresp_q <= otpsc_pkg::RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid_q && s_axi_rready)
            begin
                s_axi_rvalid_q <= 1'b0;
                s_axi_arready_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_SECTOR_LOCK: assert property (@(posedge core_clk)
        disable iff (reset)
        ce && p_row_ok |-> !sec_q[otpsc_pkg::SEC_LOCK0 + 32'(p_sect)])
        else $error("write reached a locked sector");
    AST_MASTER_LOCK: assert property (@(posedge core_clk)
        disable iff (reset)
        sec_q[otpsc_pkg::SEC_MASTER_LOCK] && running |-> !wr_go && !wr_sec_go)
        else $error("programming passed the master lock");
    AST_REFUSED_KEEPS: assert property (@(posedge core_clk)
        disable iff (reset)
        ce && ctrl_hit && !p_row_ok && !p_sec_ok && !j_wr_go
        |=> mem_q[$past(wr_idx)] == $past(mem_q[wr_idx]))
        else $error("refused programming changed contents");
    AST_JTAG_DENY: assert property (@(posedge core_clk)
        disable iff (reset)
        ce && jtag_req && running && sec_q[otpsc_pkg::SEC_JTAG_OTP_OFF]
        |=> jtag_denied_q && jtag_rdata_q == 32'h0000_0000)
        else $error("scan access not denied");
    AST_PROTECT_OUT: assert property (@(posedge core_clk)
        disable iff (reset)
        running |-> link_block_q == sec_q[otpsc_pkg::SEC_LINK_OFF]
        && jtag_block_q == sec_q[otpsc_pkg::SEC_JTAG_OFF]
        && debug_pin_off_q == sec_q[otpsc_pkg::SEC_DEBUG_OFF])
        else $error("protection output differs from word");
    AST_USERCODE: assert property (@(posedge core_clk)
        disable iff (reset)
        running |-> usercode_q == sec_q[31:22])
        else $error("user code not from upper bits");
    AST_SEC_STABLE: assert property (@(posedge core_clk)
        disable iff (reset)
        running && $past(running) |-> $stable(sec_q))
        else $error("active word changed outside a load");
    AST_BOOT_SRC: assert property (@(posedge core_clk)
        disable iff (reset)
        boot_valid_q |-> boot_otp_q == sec_q[otpsc_pkg::SEC_OTP_BOOT]
        && boot_addr_q == 11'h000)
        else $error("boot source or address wrong");
    AST_COPY_STEP: assert property (@(posedge core_clk)
        disable iff (reset)
        ce && st_q == otpsc_pkg::ST_COPY && copy_idx_q != otpsc_pkg::LAST_IDX
        |=> copy_valid_q && copy_idx_q == $past(copy_idx_q) + 11'h001)
        else $error("copy did not step by one row");
    AST_LOAD_FIRST: assert property (@(posedge core_clk)
        disable iff (reset)
        !running |-> !wr_go && !wr_sec_go && !j_allowed)
        else $error("programming before the load finished");
endmodule // otpsc_top

// ==== tb/otpsc_core_model.sv ====
// core model driving the three programming port resources
`timescale 1ns/1ns
module otpsc_core_model (
    // clock and request from the bench
    input wire logic core_clk,
    input wire logic go,
    input wire logic [15:0] row,
    input wire logic [31:0] word,
    input wire logic [15:0] cmd,
    // programming port resources
    output logic prog_we,
    output logic [23:0] prog_res_id,
    output logic [31:0] prog_wdata
);
    logic [1:0] step_q = 2'h0;
    initial
    begin
        prog_we = 1'h0;
        prog_res_id = 24'h0;
        prog_wdata = 32'h0;
    end
    // address, data, control on back-to-back cycles; idle lines toggle
    // so that a stale value can never pass for a fresh write
    always @(posedge core_clk)
    begin
        step_q <= (step_q == 2'h0) ? {1'h0, go} : step_q + 2'h1;
        prog_we <= (step_q == 2'h0) ? go : (step_q != 2'h3);
        if (step_q == 2'h0 && go)
        begin
            prog_res_id <= otpsc_pkg::RES_ADDR;
            prog_wdata <= {16'h0, row};
        end
        else if (step_q == 2'h1)
        begin
            prog_res_id <= otpsc_pkg::RES_DATA;
            prog_wdata <= word;
        end
        else if (step_q == 2'h2)
        begin
            prog_res_id <= otpsc_pkg::RES_CTRL;
            prog_wdata <= {16'h0, cmd};
        end
        else
        begin
            prog_res_id <= ~prog_res_id;
            prog_wdata <= ~prog_wdata;
        end
    end
endmodule // otpsc_core_model

// ==== tb/tb_top.sv ====
// self-checking bench for the security word block
`timescale 1ns/1ns
module tb_top;
    localparam logic [31:0] SEC_WORD = 32'h806041a2;
    logic core_clk, reset, go, prog_we, jtag_req, boot_valid_q, copy_valid_q;
    logic boot_otp_q, jtag_block_q, link_block_q, debug_pin_off_q;
    logic redundant_en_q, s_axi_awvalid, s_axi_awready_q, s_axi_wvalid;
    logic s_axi_wready_q, s_axi_bvalid_q, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready_q, s_axi_rvalid_q, s_axi_rready;
    logic [1:0] s_axi_bresp_q, s_axi_rresp_q, r;
    logic [9:0] usercode_q;
    logic rv, dn, jtag_rvalid_q, jtag_denied_q;
    logic [10:0] copy_addr_q, boot_addr_q;
    logic [31:0] copy_data_q, cp3;
    logic [10:0] jtag_addr;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [15:0] row, cmd;
    logic [23:0] prog_res_id;
    logic [31:0] prog_wdata, word, jtag_rdata_q, s_axi_wdata, s_axi_rdata_q, d;
    int err_total, tests_run, cyc, ncopy;
    otpsc_top i_otpsc_top (.core_clk, .reset, .ce(1'h1), .prog_we,
        .prog_res_id, .prog_wdata, .jtag_req, .jtag_we(1'h0), .jtag_addr,
        .jtag_wdata(32'h0), .jtag_rvalid_q, .jtag_denied_q, .jtag_rdata_q,
        .copy_valid_q, .copy_addr_q, .copy_data_q, .boot_valid_q,
        .boot_otp_q, .boot_addr_q, .jtag_block_q, .link_block_q,
        .debug_pin_off_q, .redundant_en_q, .usercode_q, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready_q, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready_q, .s_axi_bresp_q, .s_axi_bvalid_q,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready_q,
        .s_axi_rdata_q, .s_axi_rresp_q, .s_axi_rvalid_q, .s_axi_rready);
    otpsc_core_model i_otpsc_core_model (.core_clk, .go, .row, .word, .cmd,
        .prog_we, .prog_res_id, .prog_wdata);
    always #5 core_clk = ~core_clk;
    // hang ceiling and copy pulse count
    always @(posedge core_clk)
    begin
        cyc++;
        if (copy_valid_q === 1'h1) ncopy++;
        if (copy_valid_q === 1'h1 && copy_addr_q == 11'h3) cp3 = copy_data_q;
        if (cyc == 8000) begin err_total++; complete_run; end
    end
    task complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    // axi write: both channels offered, released once taken
    task wr(input logic [11:0] a, input logic [31:0] v);
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_bready <= 1'h1;
        s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready_q) s_axi_awvalid <= 1'h0;
            if (s_axi_wready_q) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid_q !== 1'h1);
        r = s_axi_bresp_q; s_axi_bready <= 1'h0;
    endtask
    task rd(input logic [11:0] a);
        s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready_q) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid_q !== 1'h1);
        d = s_axi_rdata_q; r = s_axi_rresp_q; s_axi_rready <= 1'h0;
    endtask
    // scan read: answer one edge after the request is taken
    task jt(input logic [10:0] a);
        jtag_addr <= a; jtag_req <= 1'h1;
        @(posedge core_clk);
        jtag_req <= 1'h0;
        @(posedge core_clk);
        d = jtag_rdata_q;
        dn = jtag_denied_q;
        rv = jtag_rvalid_q;
    endtask
    task prog(input logic [15:0] a, input logic [31:0] v,
        input logic [15:0] c);
        row <= a; word <= v; cmd <= c; go <= 1'h1;
        @(posedge core_clk);
        go <= 1'h0;
        repeat (4) @(posedge core_clk);
    endtask
    task wait_boot;
        do @(posedge core_clk); while (boot_valid_q !== 1'h1);
        @(posedge core_clk);
    endtask
    // main sequence
    initial
    begin
        core_clk = 0; reset = 1; go = 0; jtag_req = 0; jtag_addr = 0;
        s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0; row = 0;
        s_axi_arvalid = 0; s_axi_rready = 0; s_axi_awaddr = 0; word = 0;
        s_axi_araddr = 0; s_axi_wdata = 0; cmd = 0;
        repeat (12) @(posedge core_clk);
        reset <= 1'h0;
        wait_boot;
        chk("copies", 32'h800, ncopy);
        rd(otpsc_pkg::REG_SEC);
        chk("sec", 32'h0, d);
        chk("boot", 32'h0, boot_otp_q);
        wr(otpsc_pkg::REG_CTRL, 32'h1);
        prog(16'h3, 32'ha5c3, 16'h1);
        jt(11'h3);
        chk("row3", 32'ha5c3, d);
        chk("jans", 32'h2, {rv, dn});
        prog(16'h0, SEC_WORD, 16'h2);
        rd(otpsc_pkg::REG_SEC);
        chk("sec", 32'h0, d);
        ncopy = 0;
        wr(otpsc_pkg::REG_CTRL, 32'h3);
        wait_boot;
        chk("copies", 32'h800, ncopy);
        rd(otpsc_pkg::REG_SEC);
        chk("sec", SEC_WORD, d);
        chk("boot", 32'h1, boot_otp_q);
        chk("baddr", 32'h0, boot_addr_q);
        chk("copy3", 32'ha5c3, cp3);
        chk("prot", 32'he, {debug_pin_off_q, redundant_en_q,
            link_block_q, jtag_block_q});
        chk("ucode", 32'h201, usercode_q);
        wr(otpsc_pkg::REG_CTRL, 32'h1);
        prog(16'h3, 32'hffff0000, 16'h1);
        jt(11'h3);
        chk("row3", 32'ha5c3, d);
        rd(otpsc_pkg::REG_STATUS);
        chk("refused", 32'h1, d[1]);
        prog(16'h203, 32'hf, 16'h1);
        jt(11'h203);
        chk("row203", 32'hf, d);
        // fuse master lock and scan-memory lock, then reload
        prog(16'h0, 32'h3000, 16'h2);
        wr(otpsc_pkg::REG_CTRL, 32'h3);
        wait_boot;
        wr(otpsc_pkg::REG_STATUS, 32'h6);
        prog(16'h203, 32'hf0, 16'h1);
        jt(11'h203);
        chk("jdata", 32'h0, d);
        chk("jans", 32'h3, {rv, dn});
        rd(otpsc_pkg::REG_STATUS);
        chk("locked", 32'h87, d);
        rd(12'hffc);
        chk("resp", 32'h2, r);
        complete_run;
    end
endmodule // tb_top
